/* File: cwf_filter_config.sv */
// cwf_filter_config: mask, length-code and upper payload byte registers of the
// selective-wake detector, the configuration-valid flag, and header matching.
// assumes: register requests arrive as one-cycle strobes from the serial-port
// decoder; the identifier value and other config slices live outside.

`timescale 1ns/1ps

module cwf_filter_config
  import cwf_pkg::*;
(
  // clock and resets
  input wire logic core_clk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic restart,
  // register access
  input wire cwf_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // configuration-valid control
  input wire logic wake_config_valid_set,
  input wire logic selective_wake_event,
  input wire logic other_config_changed,
  output logic wake_config_valid,
  // frame comparison
  input wire logic [28:0] cfg_id,
  input wire cwf_rx_frame_t rx_frame,
  output cwf_match_t match,
  // configuration towards the frame decoder
  output logic [28:0] id_compare_enable,
  output logic [3:0] expected_length_code,
  output logic [3:0] expected_payload_bytes,
  output logic [7:0] expected_payload_byte_seven,
  output logic [7:0] expected_payload_byte_six,
  output logic [7:0] expected_payload_byte_five,
  output logic [7:0] expected_payload_byte_four
);

  logic [7:0] id_compare_enable_high_ff;
  logic [7:0] id_compare_enable_upper_mid_ff;
  logic [7:0] id_compare_enable_lower_mid_ff;
  logic [4:0] id_compare_enable_low_ff;
  logic [3:0] length_code_ff;
  logic [7:0] payload_seven_ff;
  logic [7:0] payload_six_ff;
  logic [7:0] payload_five_ff;
  logic [7:0] payload_four_ff;
  logic wake_config_valid_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  cwf_match_t match_ff;

  logic clear_regs;
  logic cfg_write;
  logic [7:0] nxt_rdata;
  logic [28:0] mask_all;
  logic [28:0] rx_id_aligned;
  logic [28:0] id_diff;
  logic nxt_id_match;
  logic nxt_dlc_match;

  // restart deliberately absent: contents survive it
  assign clear_regs = reset | soft_reset;

  assign cfg_write = reg_req.write &&
    (reg_req.addr >= CWF_ADDR_MASK_28_21) && (reg_req.addr <= CWF_ADDR_PAYLOAD_FOUR);

  // mask registers
  always_ff @(posedge core_clk)
  begin
    if (clear_regs)
    begin
      id_compare_enable_high_ff <= CWF_RST_BYTE;
      id_compare_enable_upper_mid_ff <= CWF_RST_BYTE;
      id_compare_enable_lower_mid_ff <= CWF_RST_BYTE;
      id_compare_enable_low_ff <= CWF_RST_MASK_LOW;
    end
    else if (reg_req.write)
    begin
      case (reg_req.addr)
        CWF_ADDR_MASK_28_21: id_compare_enable_high_ff <= reg_req.wdata;
        CWF_ADDR_MASK_20_13: id_compare_enable_upper_mid_ff <= reg_req.wdata;
        CWF_ADDR_MASK_12_5: id_compare_enable_lower_mid_ff <= reg_req.wdata;
        CWF_ADDR_MASK_4_0:
          id_compare_enable_low_ff <= reg_req.wdata[CWF_MASK_LOW_MSB:CWF_MASK_LOW_LSB];
        default:
          id_compare_enable_low_ff <= id_compare_enable_low_ff;
      endcase
    end
  end

  // length code and payload byte registers
  always_ff @(posedge core_clk)
  begin
    if (clear_regs)
    begin
      length_code_ff <= CWF_RST_DLC;
      payload_seven_ff <= CWF_RST_BYTE;
      payload_six_ff <= CWF_RST_BYTE;
      payload_five_ff <= CWF_RST_BYTE;
      payload_four_ff <= CWF_RST_BYTE;
    end
    else if (reg_req.write)
    begin
      case (reg_req.addr)
        CWF_ADDR_LENGTH_CODE: length_code_ff <= reg_req.wdata[CWF_DLC_MSB:0];
        CWF_ADDR_PAYLOAD_SEVEN: payload_seven_ff <= reg_req.wdata;
        CWF_ADDR_PAYLOAD_SIX: payload_six_ff <= reg_req.wdata;
        CWF_ADDR_PAYLOAD_FIVE: payload_five_ff <= reg_req.wdata;
        CWF_ADDR_PAYLOAD_FOUR: payload_four_ff <= reg_req.wdata;
        default:
          length_code_ff <= length_code_ff;
      endcase
    end
  end

  // configuration-valid flag; a host set in the same cycle as a clear cause other than reset wins,
  // since the host may be re-validating right after its last change
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      wake_config_valid_ff <= 1'b0;
    end
    else if (wake_config_valid_set)
    begin
      wake_config_valid_ff <= 1'b1;
    end
    else if (soft_reset || selective_wake_event || cfg_write || other_config_changed)
    begin
      wake_config_valid_ff <= 1'b0;
    end
  end

  // read mux; reserved bits are never stored, so they read zero after any restart
  always_comb
  begin
    nxt_rdata = CWF_UNMAPPED_READ;
    case (reg_req.addr)
      CWF_ADDR_MASK_28_21: nxt_rdata = id_compare_enable_high_ff;
      CWF_ADDR_MASK_20_13: nxt_rdata = id_compare_enable_upper_mid_ff;
      CWF_ADDR_MASK_12_5: nxt_rdata = id_compare_enable_lower_mid_ff;
      CWF_ADDR_MASK_4_0: nxt_rdata = {1'h0, id_compare_enable_low_ff, 2'h0};
      CWF_ADDR_LENGTH_CODE: nxt_rdata = {4'h0, length_code_ff};
      CWF_ADDR_PAYLOAD_SEVEN: nxt_rdata = payload_seven_ff;
      CWF_ADDR_PAYLOAD_SIX: nxt_rdata = payload_six_ff;
      CWF_ADDR_PAYLOAD_FIVE: nxt_rdata = payload_five_ff;
      CWF_ADDR_PAYLOAD_FOUR: nxt_rdata = payload_four_ff;
      default: nxt_rdata = CWF_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rdata_ff <= CWF_RST_BYTE;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= reg_req.read;
      if (reg_req.read)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // header comparison
  assign mask_all = {id_compare_enable_high_ff, id_compare_enable_upper_mid_ff,
                     id_compare_enable_lower_mid_ff, id_compare_enable_low_ff};

  // a standard identifier lands on 28..18; lower positions are left out of the compare
  always_comb
  begin
    rx_id_aligned = rx_frame.id;
    id_diff = (rx_frame.id ^ cfg_id) & mask_all;
    if (!rx_frame.extended)
    begin
      rx_id_aligned = {rx_frame.id[CWF_STD_ID_W-1:0], {CWF_STD_ID_LSB{1'b0}}};
      id_diff = (rx_id_aligned ^ cfg_id) & mask_all &
                {{CWF_STD_ID_W{1'b1}}, {CWF_STD_ID_LSB{1'b0}}};
    end
  end

  assign nxt_id_match = (id_diff == '0);
  assign nxt_dlc_match = (rx_frame.dlc == length_code_ff);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      match_ff <= '0;
    end
    else
    begin
      match_ff.valid <= rx_frame.valid;
      if (rx_frame.valid)
      begin
        match_ff.id_match <= nxt_id_match;
        match_ff.dlc_match <= nxt_dlc_match;
        match_ff.frame_match <= nxt_id_match && nxt_dlc_match;
      end
    end
  end

  // outputs
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign wake_config_valid = wake_config_valid_ff;
  assign match = match_ff;
  assign id_compare_enable = mask_all;
  assign expected_length_code = length_code_ff;
  // eight-to-fifteen all decode to a full payload
  assign expected_payload_bytes = (length_code_ff > CWF_DLC_MAX_DIRECT) ?
                                  CWF_PAYLOAD_FULL : length_code_ff;
  assign expected_payload_byte_seven = payload_seven_ff;
  assign expected_payload_byte_six = payload_six_ff;
  assign expected_payload_byte_five = payload_five_ff;
  assign expected_payload_byte_four = payload_four_ff;

endmodule : cwf_filter_config

/* File: cwf_filter_config_sva.sv */
// cwf_filter_config_sva: port checks of the wake filter config slice.
// assumes: one clock, synchronous active-high reset.
`timescale 1ns/1ps
module cwf_filter_config_sva
  import cwf_pkg::*;
(
  // clock and resets
  input wire logic core_clk,
  input wire logic reset,
  input wire logic soft_reset,
  // register side
  input wire cwf_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic wake_config_valid_set,
  input wire logic selective_wake_event,
  input wire logic other_config_changed,
  input wire logic wake_config_valid,
  // matching side
  input wire logic [28:0] cfg_id,
  input wire cwf_rx_frame_t rx_frame,
  input wire cwf_match_t match,
  input wire logic [28:0] id_compare_enable,
  input wire logic [3:0] expected_length_code,
  input wire logic [3:0] expected_payload_bytes
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic wr_ok;
  logic rd_now;
  // writes under soft reset are dropped, so they prove nothing
  assign wr_ok = reg_req.write && !soft_reset;
  assign rd_now = reg_req.read;
  a_mask_high: assert property (wr_ok && reg_req.addr == CWF_ADDR_MASK_28_21
    |=> id_compare_enable[28:21] == $past(reg_req.wdata)) else $error("mask high");
  a_mask_low: assert property (wr_ok && reg_req.addr == CWF_ADDR_MASK_4_0
    |=> id_compare_enable[4:0] == $past(reg_req.wdata[6:2])) else $error("mask low");
  a_low_rsvd_zero: assert property (rd_now && reg_req.addr == CWF_ADDR_MASK_4_0
    |=> (reg_rdata & 8'h83) == 8'h00) else $error("mask low reserved");
  a_dlc_rsvd_zero: assert property (rd_now && reg_req.addr == CWF_ADDR_LENGTH_CODE
    |=> reg_rdata[7:4] == 4'h0) else $error("code reserved");
  a_dlc_decode: assert property (expected_payload_bytes ==
    (expected_length_code > CWF_DLC_MAX_DIRECT ? CWF_PAYLOAD_FULL : expected_length_code))
    else $error("byte count");
  a_dlc_exact: assert property (rx_frame.valid |=> match.dlc_match ==
    ($past(rx_frame.dlc) == $past(expected_length_code))) else $error("code match");
  a_id_ext_match: assert property (rx_frame.valid && rx_frame.extended |=>
    match.id_match == ((($past(rx_frame.id) ^ $past(cfg_id)) & $past(id_compare_enable))
    == 29'h0)) else $error("id match");
  a_cfg_clear: assert property (!wake_config_valid_set && (soft_reset ||
    selective_wake_event || other_config_changed || reg_req.write &&
    reg_req.addr inside {[CWF_ADDR_MASK_28_21:CWF_ADDR_PAYLOAD_FOUR]}) |=> !wake_config_valid)
    else $error("config valid kept");
  a_cfg_set: assert property (wake_config_valid_set |=> wake_config_valid)
    else $error("config valid not set");
  a_std_id_match: assert property (rx_frame.valid && !rx_frame.extended |=>
    match.id_match == ((({$past(rx_frame.id[10:0]), 18'h0} ^ $past(cfg_id)) &
    $past(id_compare_enable) & 29'h1FFC0000) == 29'h0)) else $error("standard id match");
  c_frame: cover property (match.valid && match.frame_match);
  c_soft: cover property (soft_reset);
  c_valid_drop: cover property (wake_config_valid ##1 !wake_config_valid);
endmodule : cwf_filter_config_sva

bind cwf_filter_config cwf_filter_config_sva u_cwf_filter_config_sva (.core_clk, .reset,
  .soft_reset, .reg_req, .reg_rdata, .wake_config_valid_set, .selective_wake_event,
  .other_config_changed, .wake_config_valid, .cfg_id, .rx_frame, .match,
  .id_compare_enable, .expected_length_code, .expected_payload_bytes);

/* File: cwf_filter_config_test.sv */
// cwf_filter_config_test: register, length-code, identifier and config-valid tests.
// assumes: cwf_host drives the register side; the checker is bound to the block.
`timescale 1ns/1ps
module cwf_filter_config_test
  import cwf_pkg::*;
;
  logic core_clk, reset, restart, set, reg_rvalid, wcv;
  logic [2:0] ev;
  logic [28:0] cfg_id, idce;
  cwf_rx_frame_t rx_frame;
  cwf_reg_req_t reg_req;
  cwf_match_t match;
  logic [7:0] reg_rdata, p7, p6, p5, p4;
  logic [3:0] elc, epb;
  int err_count, n_checks;
  cwf_filter_config u_cwf_filter_config (.core_clk, .reset, .soft_reset(ev[2]), .restart,
    .reg_req, .reg_rdata, .reg_rvalid, .wake_config_valid_set(set),
    .selective_wake_event(ev[0]), .other_config_changed(ev[1]), .wake_config_valid(wcv),
    .cfg_id, .rx_frame, .match, .id_compare_enable(idce), .expected_length_code(elc),
    .expected_payload_bytes(epb), .expected_payload_byte_seven(p7),
    .expected_payload_byte_six(p6), .expected_payload_byte_five(p5),
    .expected_payload_byte_four(p4));
  cwf_host u_cwf_host (.core_clk, .reg_req, .wake_config_valid_set(set));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    u_cwf_host.access(1'b0, a, 8'h00);
    chk("rvalid", reg_rvalid, 32'h1);
    chk("rdata", reg_rdata, exp);
  endtask : rd
  task automatic frm(input logic x, input logic [28:0] id, input logic [3:0] c,
    input logic ei, input logic ed);
    @(posedge core_clk);
    #1 rx_frame = {1'b1, x, id, c};
    @(posedge core_clk);
    #1 rx_frame = {1'b0, ~x, ~id, ~c};
    chk("match", match, {28'h0, 1'b1, ei, ed, ei & ed});
  endtask : frm
  task automatic results();
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    results();
  end
  initial
  begin
    {reset, restart, ev, rx_frame, err_count, n_checks} = '0;
    reset = 1'b1;
    cfg_id = 29'h0ACE1234;
    repeat (6) @(posedge core_clk);
    #1 reset = 1'b0;
    // the tenth address is unmapped and must read zero
    for (int i = 0; i < 10; i++)
      rd(7'h27 + 7'(i), 8'h00);
    for (int i = 0; i < 9; i++)
      u_cwf_host.access(1'b1, 7'h27 + 7'(i), 8'hFF);
    for (int i = 0; i < 9; i++)
      rd(7'h27 + 7'(i), i == 3 ? 8'h7C : i == 4 ? 8'h0F : 8'hFF);
    u_cwf_host.access(1'b1, 7'h27, 8'hA5);
    u_cwf_host.access(1'b1, 7'h28, 8'h3C);
    u_cwf_host.access(1'b1, 7'h29, 8'h81);
    u_cwf_host.access(1'b1, 7'h2A, 8'h54);
    u_cwf_host.access(1'b1, 7'h2C, 8'h01);
    chk("mask", idce, {3'h0, 8'hA5, 8'h3C, 8'h81, 5'h15});
    chk("payload", {p7, p6, p5, p4}, 32'h01FFFFFF);
    @(posedge core_clk);
    #1 restart = 1'b1;
    @(posedge core_clk);
    #1 restart = 1'b0;
    rd(7'h2A, 8'h54);
    rd(7'h2B, 8'h0F);
    for (int c = 0; c < 16; c++)
    begin
      u_cwf_host.access(1'b1, 7'h2B, 8'(c));
      chk("bytes", epb, c > 7 ? 32'h8 : 32'(c));
      frm(1'b1, cfg_id, 4'(c), 1'b1, 1'b1);
      frm(1'b1, cfg_id, 4'(c ^ 1), 1'b1, 1'b0);
    end
    frm(1'b1, cfg_id ^ ~idce, 4'hF, 1'b1, 1'b1);
    frm(1'b1, cfg_id ^ 29'h10000000, 4'hF, 1'b0, 1'b1);
    frm(1'b1, cfg_id ^ 29'h00000010, 4'hF, 1'b0, 1'b1);
    frm(1'b0, {18'h3FFFF, cfg_id[28:18] ^ ~idce[28:18]}, 4'hF, 1'b1, 1'b1);
    frm(1'b0, {18'h0, cfg_id[28:18] ^ 11'h400}, 4'hF, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      u_cwf_host.cfg_valid();
      chk("cfg_valid", wcv, 32'h1);
      if (k < 3)
      begin
        @(posedge core_clk);
        #1 ev[k] = 1'b1;
        @(posedge core_clk);
        #1 ev[k] = 1'b0;
      end
      else
        u_cwf_host.access(1'b1, 7'h2F, 8'h00);
      chk("cfg_valid", wcv, 32'h0);
    end
    // host set and a wake event in the same cycle: the set wins
    fork
      u_cwf_host.cfg_valid();
      begin
        @(posedge core_clk);
        #1 ev[0] = 1'b1;
        @(posedge core_clk);
        #1 ev[0] = 1'b0;
      end
    join
    chk("cfg_valid", wcv, 32'h1);
    chk("mask", idce, 32'h0);
    chk("code", {p7, p6, p5, elc}, 32'h0);
    results();
  end
endmodule : cwf_filter_config_test

/* File: cwf_host.sv */
// cwf_host: host model issuing register strobes and config-valid pulses.
// assumes: the bench calls its tasks; idle address and data show inverted values.
`timescale 1ns/1ps
module cwf_host
  import cwf_pkg::*;
(
  // clock
  input wire logic core_clk,
  // towards the block
  output cwf_reg_req_t reg_req,
  output logic wake_config_valid_set
);
  initial
  begin
    reg_req = '0;
    wake_config_valid_set = 1'b0;
  end
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 reg_req = {wr, !wr, a, d};
    @(posedge core_clk);
    #1 reg_req = {2'h0, ~a, ~d};
  endtask : access
  // set only once the configuration is written
  task automatic cfg_valid();
    @(posedge core_clk);
    #1 wake_config_valid_set = 1'b1;
    @(posedge core_clk);
    #1 wake_config_valid_set = 1'b0;
  endtask : cfg_valid
endmodule : cwf_host

/* File: cwf_pkg.sv */
// cwf_pkg: register map, field layouts, reset values and carrier types for the
// selective-wake frame filter configuration slice.
// assumes: a serial-port frame decoder presents 7-bit register addresses and bytes.
package cwf_pkg;

  localparam int CWF_ADDR_W = 7;
  localparam int CWF_DATA_W = 8;
  localparam int CWF_ID_W = 29;
  localparam int CWF_STD_ID_W = 11;
  localparam int CWF_DLC_W = 4;

  // register addresses
  localparam logic [6:0] CWF_ADDR_MASK_28_21 = 7'h27;
  localparam logic [6:0] CWF_ADDR_MASK_20_13 = 7'h28;
  localparam logic [6:0] CWF_ADDR_MASK_12_5 = 7'h29;
  localparam logic [6:0] CWF_ADDR_MASK_4_0 = 7'h2A;
  localparam logic [6:0] CWF_ADDR_LENGTH_CODE = 7'h2B;
  localparam logic [6:0] CWF_ADDR_PAYLOAD_SEVEN = 7'h2C;
  localparam logic [6:0] CWF_ADDR_PAYLOAD_SIX = 7'h2D;
  localparam logic [6:0] CWF_ADDR_PAYLOAD_FIVE = 7'h2E;
  localparam logic [6:0] CWF_ADDR_PAYLOAD_FOUR = 7'h2F;

  // field positions
  localparam int CWF_MASK_LOW_MSB = 6;
  localparam int CWF_MASK_LOW_LSB = 2;
  localparam int CWF_MASK_LOW_W = 5;
  localparam int CWF_DLC_MSB = 3;
  localparam int CWF_STD_ID_LSB = 18;

  // reset values
  localparam logic [7:0] CWF_RST_BYTE = 8'h00;
  localparam logic [4:0] CWF_RST_MASK_LOW = 5'h00;
  localparam logic [3:0] CWF_RST_DLC = 4'h0;
  localparam logic [7:0] CWF_UNMAPPED_READ = 8'h00;

  // length-code decoding
  localparam logic [3:0] CWF_DLC_MAX_DIRECT = 4'h7;
  localparam logic [3:0] CWF_PAYLOAD_FULL = 4'h8;

  // register access from the serial-port decoder
  typedef struct packed {
    logic write;
    logic read;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cwf_reg_req_t;

  // one received wake-up frame header
  typedef struct packed {
    logic valid;
    logic extended;
    logic [28:0] id;
    logic [3:0] dlc;
  } cwf_rx_frame_t;

  // outcome of a header comparison
  typedef struct packed {
    logic valid;
    logic id_match;
    logic dlc_match;
    logic frame_match;
  } cwf_match_t;

endpackage : cwf_pkg
